/* File: design/pwm_auto_shutdown_ctrl.sv */
// Purpose: Auto-shutdown, auto-restart, dead-band and start-up control of a bridge PWM output stage
// Assumes: pclk is the oscillator clock; PWM drive and period start come from logic on pclk
// Notes:   Pin forcing on a fault is combinational so it does not wait for a clock edge
//          APB answers with zero wait states; pready stands for the access cycle only
//          Unmapped words answer with pslverr, read zero and drop their writes
//          Pin causes reach the status bit three edges after the pin moves
//          A status write loses to a synchronised cause in the same cycle
//          Auto-restart clears status one cycle after the synchronised cause drops
//          Writing one to status forces the pins as a cause would
//          Hold keeps the pins forced until a period starts with status clear
//          Dead-band adds two pipeline cycles on the A and B paths; C and D add one
//          The dead-band counter restarts on every fall of the raw drive
//          Forced levels ignore polarity; a pin drives only if its port enable is set
//          Period flag: first pulse arms, each later pulse sets, write one clears
//          Limitation: a cause shorter than one clock forces pins but may set no status
//          Limitation: polarity changes while pins drive take effect at once
//
// Notes on behaviour
// - Seven-bit dead-band count delays going active by that many instruction cycles
// - Three-bit source select picks none, comparators, fault pin or combinations
// - On shutdown A/C pins go low, high or tri-state per field
// - On shutdown B/D pins go low, high or tri-state per field
// - With auto-restart, status stays set while cause persists, then clears
// - Without auto-restart, status stays set until software clears it
// - After status clears, normal PWM resumes at next period start
// - Writes to the status bit are ignored while a selected synchronised cause is present
// - Comparator sources are levels; status cannot clear while they signal
// - Writing one to the status bit forces the shutdown state
// - Top bit of dead-band register enables auto-restart
// - Two low control bits pick polarity for A/C and B/D pairs
// - Period flag is set as the second PWM period starts
// - After reset every PWM pin is undriven
// - A shutdown event forces pins at once and sets the status bit
// - Status set at period start keeps shutdown the whole period
// - Dead-band applies only in half-bridge mode, only on going active
// - Sources are either comparator or a low level on the fault pin
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "pwm_shutdown_defs.svh"

module pwm_auto_shutdown_ctrl (
   // Clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // APB slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [11:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // From the PWM generator and port logic
   input  wire pwm_shutdown_pkg::pwm_quad_t  pwm_raw,
   input  wire logic                         period_start,
   input  wire logic                         half_bridge_mode,
   input  wire pwm_shutdown_pkg::pwm_quad_t  pin_drive_en,
   // Shutdown source pins
   input  wire logic                         fault_input_n,
   input  wire logic                         cmp1_out,
   input  wire logic                         cmp2_out,
   // Output pins
   output pwm_shutdown_pkg::pwm_quad_t       pwm_out,
   output pwm_shutdown_pkg::pwm_quad_t       pwm_out_oe,
   // Status to the system
   output logic                              period_timer_flag,
   output logic                              shutdown_active
);

   pwm_shutdown_pkg::ctrl_state_t st_q;
   pwm_shutdown_pkg::ctrl_state_t st_d;

   logic [2:0]             src_sync;
   logic                   ev_sync;
   logic                   ev_raw;
   logic                   force_sd;
   logic                   acc;
   logic                   wr;
   logic                   hit;
   logic [`DLY_W-1:0]      db_load;
   logic [`DLY_W:0]        step_a;
   logic [`DLY_W:0]        step_b;
   logic [1:0]             ac_state;
   logic [1:0]             bd_state;

   // Register strobes, named causes and pair enables
   logic                   wr_db;
   logic                   wr_sd;
   logic                   wr_cc;
   logic                   wr_st;
   logic                   flt_s;
   logic                   cmp1_s;
   logic                   cmp2_s;
   logic [`DB_COUNT_W-1:0] db_count;
   logic [1:0]             ac_pair_oe;
   logic [1:0]             bd_pair_oe;

   // Picks the selected sources out of fault, comparator 1 and comparator 2
   function automatic logic sel_event(input logic [2:0] src, input logic flt, input logic c1,
                                      input logic c2);
      logic hit_c1;
      logic hit_c2;
      logic hit_flt;
      // Code 000 matches nothing, which turns shutdown off
      hit_c1    = src[`SD_SRC_CMP1_BIT] & c1;
      hit_c2    = src[`SD_SRC_CMP2_BIT] & c2;
      hit_flt   = src[`SD_SRC_FAULT_BIT] & flt;
      sel_event = hit_c1 | hit_c2 | hit_flt;
   endfunction : sel_event

   // Address decode shared by read and write paths
   function automatic logic addr_mapped(input logic [11:0] a);
      addr_mapped = (a == `ADDR_DEAD_BAND_CONFIG) || (a == `ADDR_SHUTDOWN_CONTROL)
                 || (a == `ADDR_CAPTURE_COMPARE) || (a == `ADDR_STATUS);
   endfunction : addr_mapped

   // A fall clears the counter, so each rise waits the full delay
   // One dead-band step: returns {active, counter}
   function automatic logic [`DLY_W:0] db_step(input logic raw, input logic act,
                                               input logic [`DLY_W-1:0] cnt,
                                               input logic [`DLY_W-1:0] load, input logic hb);
      if (!hb)
         db_step = {raw, {`DLY_W{1'b0}}};
      else if (!raw)
         db_step = {1'b0, {`DLY_W{1'b0}}};
      else if (act)
         db_step = {1'b1, cnt};
      else if (cnt >= load)
         db_step = {1'b1, cnt};
      else
         db_step = {1'b0, cnt + `DLY_W'(1)};
   endfunction : db_step

   // Reset value of the synchroniser reads as no fault on every source
   // Inverted fault pin so that reset clears to "no fault"
   pin_sync2 #(
      .W(3)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({~fault_input_n, cmp2_out, cmp1_out}),
      .dout    (src_sync)
   );

   // Synchronised causes, named by source
   assign flt_s  = src_sync[2];
   assign cmp1_s = src_sync[0];
   assign cmp2_s = src_sync[1];

   // Event detection, clocked and unclocked
   assign ev_sync = sel_event(st_q.sd_ctl[`SD_SRC_MSB:`SD_SRC_LSB], flt_s, cmp1_s,
                              cmp2_s);
   // Raw cause reaches only the forcing path, never a flip-flop
   assign ev_raw  = sel_event(st_q.sd_ctl[`SD_SRC_MSB:`SD_SRC_LSB], ~fault_input_n, cmp1_out,
                              cmp2_out);

   // Bus access qualifiers
   assign acc     = psel & penable & st_q.pready;
   assign wr      = acc & pwrite & addr_mapped(paddr);
   assign hit     = addr_mapped(paddr);

   // Delay in pclk cycles; seven bits times four still fits the counter
   assign db_count = st_q.db_cfg[`DB_COUNT_MSB:0];
   assign db_load  = `DLY_W'(db_count) * `DLY_W'(`CLKS_PER_INSTR);

   // One strobe per register; each fires only on the completing access edge
   assign wr_db = wr && (paddr == `ADDR_DEAD_BAND_CONFIG);
   assign wr_sd = wr && (paddr == `ADDR_SHUTDOWN_CONTROL);
   assign wr_cc = wr && (paddr == `ADDR_CAPTURE_COMPARE);
   assign wr_st = wr && (paddr == `ADDR_STATUS);

   // Dead-band on the two half-bridge outputs
   assign step_a = db_step(pwm_raw.a, st_q.act_a, st_q.dly_a, db_load, half_bridge_mode);
   assign step_b = db_step(pwm_raw.b, st_q.act_b, st_q.dly_b, db_load, half_bridge_mode);

   // Next state
   always_comb
   begin
      st_d = st_q;

      // Plain register writes
      if (wr_db)
         st_d.db_cfg = pwdata[7:0];
      if (wr_cc)
         st_d.pol = pwdata[`POL_BD_BIT:`POL_AC_BIT];
      if (wr_sd)
         st_d.sd_ctl[`SD_SRC_MSB:0] = pwdata[`SD_SRC_MSB:0];

      // Shutdown status: event wins over any write
      // Restart clears only with no synchronised cause, so a level cause holds it
      if (ev_sync)
         st_d.sd_ctl[`SD_STATUS_BIT] = 1'b1;
      else if (wr_sd)
         st_d.sd_ctl[`SD_STATUS_BIT] = pwdata[`SD_STATUS_BIT];
      else if (st_q.db_cfg[`DB_RESTART_BIT])
         st_d.sd_ctl[`SD_STATUS_BIT] = 1'b0;

      // Hold outputs off until a period starts with status clear
      if (st_q.sd_ctl[`SD_STATUS_BIT])
         st_d.hold = 1'b1;
      else if (period_start)
         st_d.hold = 1'b0;

      // Period flag; a set in the clearing cycle wins
      // First pulse only arms, so the flag marks the second period start
      if (period_start)
         st_d.started = 1'b1;
      if (wr_st && pwdata[`ST_PERIOD_FLAG_BIT])
         st_d.ptf = 1'b0;
      if (period_start && st_q.started)
         st_d.ptf = 1'b1;

      // Status line as the pins see it, status or hold
      st_d.sd_out = st_d.sd_ctl[`SD_STATUS_BIT] | st_d.hold;

      // Dead-band and polarity on the normal path
      // Polarity applies after the delay, so the delay always guards going active
      st_d.act_a  = step_a[`DLY_W];
      st_d.dly_a  = step_a[`DLY_W-1:0];
      st_d.act_b  = step_b[`DLY_W];
      st_d.dly_b  = step_b[`DLY_W-1:0];
      st_d.norm.a = st_q.act_a ^ st_q.pol[`POL_AC_BIT];
      st_d.norm.c = pwm_raw.c ^ st_q.pol[`POL_AC_BIT];
      st_d.norm.b = st_q.act_b ^ st_q.pol[`POL_BD_BIT];
      st_d.norm.d = pwm_raw.d ^ st_q.pol[`POL_BD_BIT];
      st_d.norm_oe = pin_drive_en;

      // APB answer: ready in the first access cycle, read data staged in setup
      // Unmapped words read zero and raise pslverr; their writes are dropped
      st_d.pready  = psel & ~penable;
      st_d.pslverr = psel & ~penable & ~hit;
      st_d.prdata  = '0;
      if (psel && !penable)
      begin
         case (paddr)
            `ADDR_DEAD_BAND_CONFIG: st_d.prdata[7:0] = st_q.db_cfg;
            `ADDR_SHUTDOWN_CONTROL: st_d.prdata[7:0] = st_q.sd_ctl;
            `ADDR_CAPTURE_COMPARE:  st_d.prdata[`POL_BD_BIT:`POL_AC_BIT] = st_q.pol;
            `ADDR_STATUS:
            begin
               st_d.prdata[`ST_PERIOD_FLAG_BIT] = st_q.ptf;
               st_d.prdata[`ST_EVENT_BIT]       = ev_sync;
               st_d.prdata[`ST_HOLD_BIT]        = st_q.hold;
            end
            default: st_d.prdata = '0;
         endcase
      end
   end

   // Fields reset one by one so their values stay named
   // State register; pins undriven from reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q         <= '0;
         st_q.db_cfg  <= `RST_DEAD_BAND_CONFIG;
         st_q.sd_ctl  <= `RST_SHUTDOWN_CONTROL;
         st_q.pol     <= `RST_POLARITY;
      end
      else
         st_q <= st_d;
   end

   // Forcing path stays combinational so a fault acts without a clock edge
   assign force_sd = ev_raw | st_q.sd_ctl[`SD_STATUS_BIT] | st_q.hold;
   assign ac_state = st_q.sd_ctl[`SD_AC_MSB:`SD_AC_LSB];
   assign bd_state = st_q.sd_ctl[`SD_BD_MSB:`SD_BD_LSB];

   // Enables of each pair under shutdown; the tri-state code drops drive
   assign ac_pair_oe = {st_q.norm_oe.a, st_q.norm_oe.c} & {2{~ac_state[`SD_STATE_TRI_BIT]}};
   assign bd_pair_oe = {st_q.norm_oe.b, st_q.norm_oe.d} & {2{~bd_state[`SD_STATE_TRI_BIT]}};

   // Pin drive: shutdown level or tri-state, else the normal path
   always_comb
   begin
      pwm_out    = st_q.norm;
      pwm_out_oe = st_q.norm_oe;
      // Forced levels skip polarity; pull-downs decide undriven pins
      if (force_sd)
      begin
         pwm_out.a    = ac_state[`SD_STATE_LVL_BIT];
         pwm_out.c    = ac_state[`SD_STATE_LVL_BIT];
         pwm_out_oe.a = ac_pair_oe[1];
         pwm_out_oe.c = ac_pair_oe[0];
         pwm_out.b    = bd_state[`SD_STATE_LVL_BIT];
         pwm_out.d    = bd_state[`SD_STATE_LVL_BIT];
         pwm_out_oe.b = bd_pair_oe[1];
         pwm_out_oe.d = bd_pair_oe[0];
      end
   end

   // Registered outputs
   // Pins are left out on purpose: their forcing must not wait for an edge
   assign prdata            = st_q.prdata;
   assign pready            = st_q.pready;
   assign pslverr           = st_q.pslverr;
   assign period_timer_flag = st_q.ptf;
   assign shutdown_active   = st_q.sd_out;

endmodule : pwm_auto_shutdown_ctrl

/* File: design/pwm_shutdown_defs.svh */
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef PWM_SHUTDOWN_DEFS_SVH
`define PWM_SHUTDOWN_DEFS_SVH

// Register byte addresses
`define ADDR_DEAD_BAND_CONFIG   12'h000
`define ADDR_SHUTDOWN_CONTROL   12'h004
`define ADDR_CAPTURE_COMPARE    12'h008
`define ADDR_STATUS             12'h00c

// Dead-band configuration fields
`define DB_RESTART_BIT          7
`define DB_COUNT_MSB            6
`define DB_COUNT_W              7

// Shutdown control fields
`define SD_STATUS_BIT           7
`define SD_SRC_MSB              6
`define SD_SRC_LSB              4
`define SD_AC_MSB               3
`define SD_AC_LSB               2
`define SD_BD_MSB               1
`define SD_BD_LSB               0
`define SD_SRC_CMP1_BIT         0
`define SD_SRC_CMP2_BIT         1
`define SD_SRC_FAULT_BIT        2
`define SD_STATE_TRI_BIT        1
`define SD_STATE_LVL_BIT        0

// Capture/compare control: polarity bits
`define POL_AC_BIT              0
`define POL_BD_BIT              1

// Status register bits
`define ST_PERIOD_FLAG_BIT      0
`define ST_EVENT_BIT            1
`define ST_HOLD_BIT             2

// Reset values
`define RST_DEAD_BAND_CONFIG    8'h00
`define RST_SHUTDOWN_CONTROL    8'h00
`define RST_POLARITY            2'h0

// Timing: one instruction cycle is four oscillator (pclk) cycles
`define CLKS_PER_INSTR          4
`define DLY_W                   9

`endif

/* File: design/pwm_shutdown_pkg.sv */
// Purpose: Types shared by the auto-shutdown controller
// Assumes: Constants come from pwm_shutdown_defs.svh
// Notes:   No parameters of its own
`include "pwm_shutdown_defs.svh"

package pwm_shutdown_pkg;

   // One bit for each output pin of the bridge
   typedef struct packed {
      logic a;
      logic b;
      logic c;
      logic d;
   } pwm_quad_t;

   // Whole state of the controller
   typedef struct packed {
      logic [7:0]              db_cfg;
      logic [7:0]              sd_ctl;
      logic [1:0]              pol;
      logic                    hold;
      logic                    started;
      logic                    ptf;
      logic                    sd_out;
      logic [`DLY_W-1:0]       dly_a;
      logic [`DLY_W-1:0]       dly_b;
      logic                    act_a;
      logic                    act_b;
      pwm_quad_t               norm;
      pwm_quad_t               norm_oe;
      logic [31:0]             prdata;
      logic                    pready;
      logic                    pslverr;
   } ctrl_state_t;

endpackage : pwm_shutdown_pkg

/* File: design/pin_sync2.sv */
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are levels, not pulses
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps

module pin_sync2 #(
   parameter int W = 3
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t st_q;
   sync_state_t st_d;

   // Shift chain
   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
   end

   // Clears to the inactive level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign dout = st_q.s2;

endmodule : pin_sync2

/* File: testbench/pwm_shutdown_props.sv */
// Purpose: Port-level assertions for the auto-shutdown controller
// Assumes: Shadows of source, pin-state and restart fields follow APB writes
// Notes:   Bound to the controller at the foot of this file
`timescale 1ns/1ps
module pwm_shutdown_props (
   // Clock and reset
   input wire logic                        pclk,
   input wire logic                        presetn,
   // APB
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [11:0]                 paddr,
   input wire logic [31:0]                 pwdata,
   input wire logic                        pready,
   // Timer and causes
   input wire logic                        period_start,
   input wire logic                        fault_input_n,
   input wire logic                        cmp1_out,
   input wire logic                        cmp2_out,
   // Pins and status
   input wire pwm_shutdown_pkg::pwm_quad_t pwm_out,
   input wire pwm_shutdown_pkg::pwm_quad_t pwm_out_oe,
   input wire logic                        period_timer_flag,
   input wire logic                        shutdown_active
);
   logic [6:0] cfg_q;
   logic       rs_q;
   logic       wr;
   logic       ev;
   logic       sd;
   // Completed write to either configuration register
   assign wr = psel && penable && pready && pwrite && paddr[11:3] == 9'h000;
   // Shadow fields, so checks need no view inside the design
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         {rs_q, cfg_q} <= 8'h00;
      else if (wr && paddr[2])
         cfg_q <= pwdata[6:0];
      else if (wr)
         rs_q <= pwdata[7];
   // Raw selected cause, ahead of any synchroniser
   assign ev = cfg_q[4] && cmp1_out || cfg_q[5] && cmp2_out || cfg_q[6] && !fault_input_n;
   assign sd = ev || shutdown_active;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_IDLE_AT_RELEASE: assert property ($rose(presetn) |-> pwm_out_oe == 4'h0)
      else $error("pins driven at reset release");
   AST_TRI_AC: assert property (sd && cfg_q[3] |-> !pwm_out_oe.a && !pwm_out_oe.c)
      else $error("pair a/c not released");
   AST_LVL_AC: assert property (sd && !cfg_q[3] && pwm_out_oe.a |-> pwm_out.a == cfg_q[2])
      else $error("pair a/c wrong level");
   AST_TRI_BD: assert property (sd && cfg_q[1] |-> !pwm_out_oe.b && !pwm_out_oe.d)
      else $error("pair b/d not released");
   AST_LVL_BD: assert property (sd && !cfg_q[1] && pwm_out_oe.d |-> pwm_out.d == cfg_q[0])
      else $error("pair b/d wrong level");
   AST_SET_BY_EVENT: assert property (ev [*4] |-> shutdown_active)
      else $error("status not set by cause");
   AST_WRITE_IGNORED: assert property (ev [*3] ##1 ev && wr && paddr[2] |=> shutdown_active)
      else $error("status cleared during cause");
   AST_FORCE_BY_WRITE: assert property (wr && paddr[2] && pwdata[7] |=> shutdown_active)
      else $error("write of one did not force");
   AST_NO_RESTART: assert property (shutdown_active && !rs_q && !wr && !period_start |=> shutdown_active)
      else $error("status cleared without software");
   AST_AUTO_RESTART: assert property ((rs_q && !ev && !wr) [*6] ##0 period_start |=> !shutdown_active)
      else $error("no restart after cause left");
   AST_RESUME_AT_PERIOD: assert property ($fell(shutdown_active) |-> $past(period_start))
      else $error("resumed away from period start");
   AST_FLAG_AT_PERIOD: assert property ($rose(period_timer_flag) |-> $past(period_start))
      else $error("flag set away from period start");
endmodule : pwm_shutdown_props

bind pwm_auto_shutdown_ctrl pwm_shutdown_props u_pwm_shutdown_props (.*);

/* File: testbench/bridge_model.sv */
// Purpose: Bridge switch drivers and current comparators beside the controller
// Assumes: Pull-downs on every PWM pin keep the switches off when undriven
// Notes:   Causes move on the falling edge, unrelated to the bus sampling
`timescale 1ns/1ps
module bridge_model (
   // Clock and causes: [0] comparator 1, [1] comparator 2, [2] fault pin
   input  wire logic                        pclk,
   input  wire logic [2:0]                  trip,
   // PWM pins
   input  wire pwm_shutdown_pkg::pwm_quad_t pwm_out,
   input  wire pwm_shutdown_pkg::pwm_quad_t pwm_out_oe,
   // Gate levels and shutdown sources
   output pwm_shutdown_pkg::pwm_quad_t      gate,
   output logic                             cmp1_out = 1'b0,
   output logic                             cmp2_out = 1'b0,
   output logic                             fault_input_n = 1'b1
);
   // Analogue outputs are levels; fault pin idles high via its pull-up
   always @(negedge pclk)
   begin
      cmp1_out <= trip[0];
      cmp2_out <= trip[1];
      fault_input_n <= !trip[2];
   end
   // Undriven pin reads as the pull-down level
   assign gate = pwm_out & pwm_out_oe;
endmodule : bridge_model

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the auto-shutdown controller
// Assumes: Zero-wait APB slave; one period is one period_start pulse
// Notes:   Pin states, raw drive and dead-band count drawn from a fixed seed
`timescale 1ns/1ps
`define CHK(n, e, g) begin @(negedge pclk); comparisons++; \
   if ((g) !== (e)) begin fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
   logic                        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic                        period_start = 1'b0, half_bridge_mode = 1'b0, pready, pslverr, pe;
   logic                        cmp1_out, cmp2_out, fault_input_n, period_timer_flag, shutdown_active;
   logic [11:0]                 paddr = 12'h000;
   logic [31:0]                 pwdata = 32'h0, prdata, rd;
   logic [2:0]                  trip = 3'h0;
   logic [1:0]                  pol;
   logic [7:0]                  sdc;
   logic [6:0]                  db;
   pwm_shutdown_pkg::pwm_quad_t pwm_raw = 4'h0, pin_drive_en = 4'h0, pwm_out, pwm_out_oe, gate;
   int                          fail_count = 0, comparisons = 0, n;
   pwm_auto_shutdown_ctrl u_pwm_auto_shutdown_ctrl (.*);
   bridge_model u_bridge_model (.*);
   // Clock, 5 ns period
   always #2.5 pclk = ~pclk;
   // Expected enables and gate levels; forced state ignores polarity
   function automatic logic [7:0] pins(input logic sd, input logic [7:0] c, input logic [3:0] r);
      logic [3:0] oe;
      logic [3:0] lv;
      oe = sd ? {!c[3], !c[1], !c[3], !c[1]} : 4'hf;
      lv = sd ? {c[2], c[0], c[2], c[0]} : r ^ {pol[0], pol[1], pol[0], pol[1]};
      return {oe, lv & oe};
   endfunction : pins
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      pe = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Causes, raw drive and bridge mode change together on an edge
   task automatic drv(input logic [2:0] t, input logic [3:0] r, input logic hb);
      @(posedge pclk);
      trip <= t;
      pwm_raw <= r;
      half_bridge_mode <= hb;
   endtask : drv
   // Timer pulse, then room for the output pipeline
   task automatic period();
      @(posedge pclk);
      period_start <= 1'b1;
      @(posedge pclk);
      period_start <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : period
   task automatic end_sim();
      if (fail_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   // Hang guard; the planned run is well under two thousand cycles
   initial
   begin
      #100000;
      fail_count++;
      end_sim();
   end
   initial
   begin
      void'($urandom(32'h7742b648));
      pol = 2'($urandom());
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("oe after reset", 4'h0, pwm_out_oe)
      // Reset values, then one unmapped word
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, 12'(4 * i), 32'h0);
         `CHK("reset value", 32'h0, rd)
         `CHK("slave error", 1'(i == 4), pe)
      end
      // Polarity first, pins only after a whole period
      apb(1'b1, 12'h008, {30'h0, pol});
      period();
      `CHK("flag after first period", 1'b0, period_timer_flag)
      period();
      `CHK("flag after second period", 1'b1, period_timer_flag)
      @(posedge pclk);
      pin_drive_en <= 4'hf;
      apb(1'b1, 12'h00c, 32'h1);
      `CHK("flag cleared", 1'b0, period_timer_flag)
      // Every source code against each single cause; clear tried mid-event
      for (int s = 0; s < 8; s++)
         for (int k = 0; k < 3; k++)
         begin
            sdc = {1'b0, 3'(s), 4'($urandom())};
            apb(1'b1, 12'h004, {24'h0, sdc});
            drv(3'b001 << k, 4'($urandom()), 1'b0);
            repeat (5) @(posedge pclk);
            apb(1'b1, 12'h004, {24'h0, sdc});
            `CHK("event status", s[k], shutdown_active)
            apb(1'b0, 12'h004, 32'h0);
            `CHK("control readback", {24'h0, s[k], sdc[6:0]}, rd)
            apb(1'b0, 12'h00c, 32'h0);
            `CHK("cause and hold", {s[k], s[k]}, rd[2:1])
            `CHK("pins in event", pins(s[k], sdc, pwm_raw), {pwm_out_oe, gate})
            drv(3'h0, pwm_raw, 1'b0);
            repeat (6) @(posedge pclk);
            `CHK("status held", s[k], shutdown_active)
            apb(1'b1, 12'h004, {24'h0, sdc});
            `CHK("hold until period", s[k], shutdown_active)
            period();
            `CHK("normal pins", pins(1'b0, sdc, pwm_raw), {pwm_out_oe, gate})
         end
      // Auto-restart on a comparator level, then a forced shutdown by write
      apb(1'b1, 12'h000, 32'h80);
      apb(1'b1, 12'h004, 32'h10);
      drv(3'h1, pwm_raw, 1'b0);
      repeat (8) @(posedge pclk);
      `CHK("comparator level", 1'b1, shutdown_active)
      drv(3'h0, pwm_raw, 1'b0);
      repeat (8) @(posedge pclk);
      `CHK("restart waits for period", 1'b1, shutdown_active)
      period();
      `CHK("auto restart", 1'b0, shutdown_active)
      apb(1'b1, 12'h004, 32'h90);
      `CHK("forced by write", 8'hf0, {pwm_out_oe, gate})
      period();
      // Dead band on going active, in and out of half-bridge mode
      db = 7'($urandom_range(20, 1));
      apb(1'b1, 12'h000, {25'h0, db});
      for (int hb = 1; hb >= 0; hb--)
      begin
         drv(3'h0, 4'h0, 1'(hb));
         repeat (4 * db + 8) @(posedge pclk);
         drv(3'h0, 4'h8, 1'(hb));
         n = 0;
         while (pwm_out.a !== !pol[0])
         begin
            @(negedge pclk);
            n++;
         end
         `CHK("rise delay", 1'b1, n >= hb * db * 4 + 1 && n <= hb * db * 4 + 4)
         drv(3'h0, 4'h0, 1'(hb));
         repeat (3) @(posedge pclk);
         `CHK("fall at once", pol[0], pwm_out.a)
      end
      end_sim();
   end
endmodule : tb_top
